// *** hw/tob_bank.sv ***
// Trim option bank: Wishbone slave over nonvolatile trim bytes
module tob_bank #(
  parameter bit EIGHT_PIN = 1'b1
) (
  // Clock, warm reset, power-on load
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  // Wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [tob_pkg::TOB_ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Trim consumers
  output logic [7:0] precision_osc_trim_o,
  output logic [tob_pkg::TOB_FIELD_W-1:0] threshold_trim_field_o,
  output logic [11:0] detect_threshold_level_o,
  output logic low_voltage_detector_present_o
);
  import tob_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  // The store address is three bits wide, so at most eight trim bytes
  if (TOB_TRIM_COUNT < 1 || TOB_TRIM_COUNT > 8) begin : g_bad_count
    $error("tob_bank: trim byte count must be 1 to 8");
  end
  // The field must sit in the low bits, under the three fixed upper bits
  if (TOB_FIELD_MSB + 1 != TOB_FIELD_W || TOB_FIELD_W > 5) begin : g_bad_field
    $error("tob_bank: detector field layout does not fit the byte");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus timing
  //
  // Cycle 0: request stands in idle; the store latches the addressed byte at its end.
  // Cycle 1: fetch; a write lands in the store and in the trim copies at its end.
  // Cycle 2: ack stands for this one cycle; read data holds until the next fetch.
  // Cycle 3: idle again; the next request may be taken from here on.
  // Every transfer is acknowledged, refused ones with no effect and zero data,
  // so a master never hangs on an unmapped or unaligned address.

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // True when a store write hits the given trim address
  function automatic logic writes_byte(input logic we, input logic [2:0] addr, input logic [2:0] target);
    return we && addr == target;
  endfunction

  // Status word: detector present and last bad upper-bit write
  function automatic logic [31:0] status_word(input logic pres, input logic bad);
    logic [31:0] w;
    w = '0;
    w[TOB_ST_PRESENT] = pres;
    w[TOB_ST_UPPER_BAD] = bad;
    return w;
  endfunction

  // Threshold in millivolts from the field
  function automatic logic [11:0] level_mv(input logic [TOB_FIELD_W-1:0] f);
    logic [11:0] drop;
    drop = 12'(f * TOB_STEP_MV);
    return TOB_TOP_MV - drop;
  endfunction

  // True when a word index hits one of the trim bytes
  function automatic logic is_trim(input logic [5:0] idx);
    return idx >= TOB_INFO_BASE && idx < TOB_INFO_BASE + 6'(TOB_TRIM_COUNT);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Bus state
  tob_state_e state;
  tob_state_e next_state;
  logic ack;
  logic next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  // Trim copies for the consumers
  logic [7:0] osc;
  logic [7:0] next_osc;
  logic [TOB_FIELD_W-1:0] field;
  logic [TOB_FIELD_W-1:0] next_field;
  logic [11:0] level;
  logic [11:0] next_level;
  logic upper_bad;
  logic next_upper_bad;
  logic [TOB_FIELD_W-1:0] field_shown;
  logic [TOB_FIELD_W-1:0] next_field_shown;
  logic present_shown;
  // Address decode and store access
  logic present;
  logic [5:0] idx;
  logic [2:0] trim_addr;
  logic aligned;
  logic store_we;
  logic [7:0] store_rdata;
  logic [TOB_TRIM_COUNT*8-1:0] init_bytes;

  assign idx = adr_i[7:2];
  assign aligned = adr_i[1:0] == 2'h0;
  assign trim_addr = 3'(idx - TOB_INFO_BASE); // see RULE1
  assign present = EIGHT_PIN; // see RULE8
  assign init_bytes = {TOB_DEF_RSVD, TOB_DEF_THRESH, TOB_DEF_OSC, TOB_DEF_RSVD, TOB_DEF_RSVD};

  // Write takes effect once, on the fetch cycle of the transfer
  assign store_we = state == TOB_FETCH && we_i && sel_i[0] && aligned && is_trim(idx); // see RULE1

  ////////////////////////////////////////////////////////////////////////////
  // Byte store, untouched by warm reset

  tob_store #(
    .DEPTH(TOB_TRIM_COUNT),
    .WIDTH(8)
  ) u_store (
    .clk_i(clk_i),
    .por_i(por_i),
    .init_i(init_bytes),
    .we_i(store_we), // see RULE2
    .waddr_i(trim_addr),
    .wdata_i(dat_i[7:0]),
    .raddr_i(trim_addr),
    .rdata_o(store_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus sequencing: take request, fetch, answer with ack

  always_comb begin
    next_state = state;
    next_ack = 1'b0;
    next_rdata = rdata;
    unique case (state)
      TOB_IDLE: begin
        if (cyc_i && stb_i) begin
          next_state = TOB_FETCH;
        end
      end
      TOB_FETCH: begin
        next_state = TOB_ANSWER;
        next_ack = 1'b1;
        next_rdata = '0;
        if (!we_i && aligned) begin
          if (is_trim(idx)) begin
            next_rdata = {24'h0, store_rdata};
          end else if (idx == TOB_STATUS_IDX) begin
            next_rdata = status_word(present, upper_bad); // see RULE8
          end else if (idx == TOB_LEVEL_IDX) begin
            next_rdata = {20'h0, level};
          end
        end
      end
      TOB_ANSWER: begin
        next_state = TOB_IDLE;
      end
      // The unused fourth code falls back to idle
      default: begin
        next_state = TOB_IDLE;
      end
    endcase
  end

  // Bus state; warm reset clears only the state, ack and read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= TOB_IDLE;
      ack <= 1'b0;
      rdata <= '0;
    end else begin
      state <= next_state;
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  assign ack_o = ack;
  assign dat_o = rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Consumer copies of the trim values, loaded with the store

  // Power-on load wins over a write in the same cycle
  always_comb begin
    next_osc = osc;
    next_field = field;
    next_upper_bad = upper_bad;
    if (por_i) begin
      next_osc = TOB_DEF_OSC; // see RULE9
      next_field = TOB_DEF_THRESH[TOB_FIELD_MSB:0];
      next_upper_bad = 1'b0;
    end else if (writes_byte(store_we, trim_addr, TOB_OSC)) begin
      next_osc = dat_i[7:0]; // see RULE4
    end else if (writes_byte(store_we, trim_addr, TOB_THRESH)) begin
      next_field = dat_i[TOB_FIELD_MSB:0]; // see RULE6
      next_upper_bad = dat_i[7:5] != TOB_UPPER_ONES; // see RULE5
    end
    // Field and level come from the same next value so they move together
    next_field_shown = present ? next_field : '0; // see RULE8
    next_level = present ? level_mv(next_field) : 12'h000; // see RULE7
  end

  // No warm reset here: trims persist across it
  always_ff @(posedge clk_i) begin
    osc <= next_osc; // see RULE2
    field <= next_field;
    upper_bad <= next_upper_bad;
    level <= next_level;
    field_shown <= next_field_shown;
    present_shown <= present;
  end

  // Outputs leave straight from the flops above
  assign precision_osc_trim_o = osc; // see RULE9
  assign threshold_trim_field_o = field_shown; // see RULE8
  assign detect_threshold_level_o = level;
  assign low_voltage_detector_present_o = present_shown;
endmodule

// *** include/tob_pkg.sv ***
// Constants for the trim option bank
// Summary of operation
// RULE1 - Trim byte sits at page base plus address
// RULE2 - Warm reset leaves every trim byte unchanged
// RULE3 - Software leaves reserved bytes 0, 1, 4 alone
// RULE4 - Byte 2 bits 7:0 trim precision oscillator
// RULE5 - Software writes byte 3 bits 7:5 as 111
// RULE6 - Byte 3 bits 4:0 trim detector, 50mV steps
// RULE7 - Threshold: 3.6 V minus field times 0.05 V
// RULE8 - Low voltage detector exists on eight-pin parts only
// RULE9 - Trim values drive consumers continuously after load
package tob_pkg;
  localparam int TOB_TRIM_COUNT = 5;
  localparam int TOB_ADDR_W = 8;
  // Word index of trim address 0 in the information page
  localparam logic [5:0] TOB_INFO_BASE = 6'h20;
  // Trim addresses
  localparam logic [2:0] TOB_RSVD_A = 3'h0;
  localparam logic [2:0] TOB_RSVD_B = 3'h1;
  localparam logic [2:0] TOB_OSC = 3'h2;
  localparam logic [2:0] TOB_THRESH = 3'h3;
  localparam logic [2:0] TOB_RSVD_C = 3'h4;
  // Extra word indices: status and computed threshold
  localparam logic [5:0] TOB_STATUS_IDX = 6'h28;
  localparam logic [5:0] TOB_LEVEL_IDX = 6'h29;
  // Status bit positions
  localparam int TOB_ST_PRESENT = 0;
  localparam int TOB_ST_UPPER_BAD = 1;
  // Low voltage trim field layout
  localparam int TOB_FIELD_MSB = 4;
  localparam int TOB_FIELD_W = 5;
  localparam logic [2:0] TOB_UPPER_ONES = 3'h7;
  // Contents loaded at power on (erased reserved, mid oscillator, field 01010)
  localparam logic [7:0] TOB_DEF_RSVD = 8'hff;
  localparam logic [7:0] TOB_DEF_OSC = 8'h80;
  localparam logic [7:0] TOB_DEF_THRESH = 8'hea;
  // Threshold arithmetic in millivolts
  localparam logic [11:0] TOB_TOP_MV = 12'he10;
  localparam logic [11:0] TOB_STEP_MV = 12'h032;
  typedef enum logic [1:0] {TOB_IDLE, TOB_FETCH, TOB_ANSWER} tob_state_e;
endpackage

// *** hw/tob_store.sv ***
// Small byte store for the trim bytes, registered read data
module tob_store #(
  parameter int DEPTH = 5,
  parameter int WIDTH = 8
) (
  // Clock and power-on load
  input wire logic clk_i,
  input wire logic por_i,
  input wire logic [DEPTH*WIDTH-1:0] init_i,
  // Write port
  input wire logic we_i,
  input wire logic [2:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  // Read port
  input wire logic [2:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_rdata;

  // The address ports are three bits wide
  if (DEPTH < 1 || DEPTH > 8 || WIDTH < 1) begin : g_bad_depth
    $error("tob_store: DEPTH must be 1 to 8 and WIDTH at least 1");
  end

  // Read mux; out of range reads as zero
  always_comb begin
    next_rdata = '0;
    if (int'(raddr_i) < DEPTH) begin
      next_rdata = mem[raddr_i];
    end
  end

  // Contents load only at power on or on a write; warm reset never touches them
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (por_i) begin
        mem[i] <= init_i[i*WIDTH +: WIDTH];
      end else if (we_i && int'(waddr_i) == i) begin
        mem[i] <= wdata_i;
      end
    end
    rdata_o <= next_rdata;
  end
endmodule

// *** tb/tob_bank_properties.sv ***
// Port checker for the trim option bank
module tob_bank_chk #(
  parameter bit EIGHT_PIN = 1'b1
) (
  // Clock and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  // Wishbone side
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [tob_pkg::TOB_ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Trim consumers
  input wire logic [7:0] precision_osc_trim_o,
  input wire logic [tob_pkg::TOB_FIELD_W-1:0] threshold_trim_field_o,
  input wire logic [11:0] detect_threshold_level_o,
  input wire logic low_voltage_detector_present_o
);
  import tob_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || por_i);
  // Start of a request of one direction at one byte address
  sequence s_req(logic w, logic [7:0] a);
    $rose(cyc_i && stb_i && we_i == w && adr_i == a && sel_i[0]);
  endsequence
  // Answer one cycle after a quiet cycle
  sequence s_ans;
    !ack_o ##1 ack_o;
  endsequence
  a_ack_delay: assert property ($rose(cyc_i && stb_i) |-> !ack_o ##1 s_ans) else $error("ack late");
  a_osc_write: assert property (s_req(1'b1, 8'h88) |-> ##2 precision_osc_trim_o == $past(dat_i[7:0], 2))
    else $error("osc trim not written");
  a_field_write: assert property (s_req(1'b1, 8'h8c) |-> ##2
    threshold_trim_field_o == (EIGHT_PIN ? $past(dat_i[4:0], 2) : 5'h00)) else $error("field wrong");
  a_level_calc: assert property (detect_threshold_level_o ==
    (EIGHT_PIN ? 12'he10 - 12'h032 * 12'(threshold_trim_field_o) : 12'h000)) else $error("level wrong");
  a_det_flag: assert property (low_voltage_detector_present_o == EIGHT_PIN) else $error("present wrong");
  a_warm_keep: assert property (disable iff (por_i) rst_i |=> $stable(precision_osc_trim_o) &&
    $stable(threshold_trim_field_o)) else $error("trim lost on reset");
  a_trim_hold: assert property (!ack_o |-> $stable(precision_osc_trim_o)) else $error("trim moved");
  a_read_osc: assert property (s_req(1'b0, 8'h88) |-> ##2 ack_o && dat_o[7:0] == precision_osc_trim_o)
    else $error("read wrong");
endmodule
bind tob_bank tob_bank_chk #(.EIGHT_PIN(EIGHT_PIN)) u_chk (.*);

// *** tb/tb_top.sv ***
// Self-checking bench for the trim option bank
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import tob_pkg::*;
  logic clk_i = 0, rst_i = 1, por_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [7:0] adr_i = 8'h00, o;
  logic [3:0] sel_i = 4'h1;
  logic [31:0] dat_i = 32'h0, dat_o, q[$];
  logic ack_o, pres;
  logic [7:0] osc;
  logic [4:0] fld, f;
  logic [11:0] lvl;
  int checks = 0, num_errors = 0;
  tob_bank dut (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .precision_osc_trim_o(osc),
    .threshold_trim_field_o(fld), .detect_threshold_level_o(lvl), .low_voltage_detector_present_o(pres));
  always #12.5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////
  // Compare one value and count it
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  // Classic single cycle, entered just after a rising edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'h1;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc_i <= 0; stb_i <= 0; we_i <= 0;
    @(posedge clk_i);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(0, a, 32'h0);
  endtask
  // Outputs follow the last good write
  task outs(input logic [7:0] eo, input logic [4:0] ef);
    chk("osc", 32'(eo), 32'(osc));
    chk("field", 32'(ef), 32'(fld));
    chk("level", 32'(3600 - 50 * ef), 32'(lvl));
    chk("present", 32'h1, 32'(pres));
  endtask
  task test_done;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Read answers are checked against the oldest note
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0) chk("read", q.pop_front(), dat_o);
  end
  // Watchdog
  initial begin
    repeat (4000) @(posedge clk_i);
    num_errors++;
    test_done();
  end
  // Main sequence
  initial begin
    void'($urandom(6810));
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    por_i <= 0;
    @(posedge clk_i);
    q.delete();
    rd(8'h80, 32'hff);
    rd(8'h84, 32'hff);
    rd(8'h88, 32'h80);
    rd(8'h8c, 32'hea);
    rd(8'h90, 32'hff);
    rd(8'ha0, 32'h1);
    rd(8'ha4, 32'hc1c);
    rd(8'hb0, 32'h0);
    rd(8'h8a, 32'h0);
    $display("test defaults done");
    // Reserved bytes are never written; upper bits of byte 3 always 111
    for (int i = 0; i < 5; i++) begin
      o = 8'($urandom);
      f = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($urandom);
      bus(1, 8'h88, 32'(o));
      bus(1, 8'h8c, {24'h0, 3'h7, f});
      outs(o, f);
      rd(8'h88, 32'(o));
      rd(8'h8c, {24'h0, 3'h7, f});
      rd(8'ha4, 32'(3600 - 50 * f));
    end
    bus(1, 8'ha4, 32'h0);
    rd(8'ha4, 32'(3600 - 50 * f));
    bus(1, 8'h8a, 32'h55);
    rd(8'h88, 32'(o));
    rd(8'ha0, 32'h1);
    $display("test writes done");
    rst_i <= 1;
    @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    outs(o, f);
    rd(8'h88, 32'(o));
    rd(8'h8c, {24'h0, 3'h7, f});
    rd(8'h80, 32'hff);
    $display("test warm reset done");
    test_done();
  end
endmodule
